// >>> hdl/lcr_host.sv
// Purpose: host lane end of contention recovery
// Assumes: fault flags come asynchronously from the I/O cell
// Notes:   reset entry is a level strobe on the link, not escape-coded
// Summary of operation
// - two fault flags: drive high, drive low
// - faults only on bidirectional lanes
// - handle both, host only, peripheral only
// - host fault: drive LP-11, start wait
// - peripheral fault: receive, await stop state
// - after wait, optional reset entry request
// - peripheral resets on reset entry, stays receiving
// - after reset entry: LP-11, reset timeout, resume
// - host-only case: peripheral recovers by possession timeout
// - peripheral-only case: host makes normal stop
// - reset policy: single, several, or never
`timescale 1ns/1ps
`include "lcr_cfg.svh"
module lcr_host (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // i/o cell faults
    input  wire logic                drive_high_contention_fault,
    input  wire logic                drive_low_contention_fault,
    // configuration
    input  wire logic                lane_bidir,
    input  wire lcr_pkg::lcr_policy_t policy,
    input  wire logic [`LCR_THR_W-1:0] fault_threshold,
    input  wire lcr_pkg::lcr_cnt_t   host_wait_cycles,
    input  wire lcr_pkg::lcr_cnt_t   periph_rst_cycles,
    // user traffic
    input  wire logic                tx_req,
    input  wire logic                tx_p,
    input  wire logic                tx_n,
    output logic                     busy,
    output logic                     fault_seen,
    // link
    lcr_link_if.host                 link
);
    typedef enum logic [2:0] {
        LCR_H_NORMAL = 3'h0,
        LCR_H_WAIT   = 3'h1,
        LCR_H_RSTTX  = 3'h2,
        LCR_H_RSTWT  = 3'h3
    } lcr_hstate_t;

    lcr_hstate_t                  state_q;
    lcr_hstate_t                  state_d;
    wire  [1:0]                   fault_raw;
    wire  [1:0]                   fault_sync;
    lcr_pkg::lcr_cnt_t            tmr_q;
    logic [`LCR_THR_W-1:0]        count_q;
    logic [3:0]                   div_q;
    logic                         lclk_q;
    logic                         p_q;
    logic                         n_q;
    logic                         oe_n_q;
    logic                         rst_entry_q;
    logic                         busy_q;
    logic                         fault_q;

    // state test shared by the timer, the counter and the drive logic
    function automatic logic in_normal(input lcr_hstate_t s);
        return (s == LCR_H_NORMAL);
    endfunction : in_normal

    // never, always, or once the count reaches the threshold
    function automatic logic policy_wants_reset(
        input lcr_pkg::lcr_policy_t  pol,
        input logic [`LCR_THR_W-1:0] cnt,
        input logic [`LCR_THR_W-1:0] thr
    );
        logic hit;
        hit = 1'b0;
        unique case (pol)
            lcr_pkg::LCR_POL_NEVER:  hit = 1'b0;
            lcr_pkg::LCR_POL_SINGLE: hit = 1'b1;
            lcr_pkg::LCR_POL_MULTI:  hit = (cnt >= thr);
            default:                 hit = 1'b0;
        endcase
        return hit;
    endfunction : policy_wants_reset

    assign fault_raw = {drive_high_contention_fault, drive_low_contention_fault};
    wire fault_hit  = lane_bidir & (|fault_sync);
    wire tmr_done   = (tmr_q == '0);
    wire [`LCR_THR_W-1:0] count_inc = count_q + 1'b1;
    wire want_reset = policy_wants_reset(policy, count_q, fault_threshold);
    wire enter_wait  = in_normal(state_q) & (state_d == LCR_H_WAIT);
    wire enter_rstwt = (state_q == LCR_H_RSTTX) & (state_d == LCR_H_RSTWT);
    wire count_step  = in_normal(state_q) & fault_hit & (count_inc != '0);
    wire count_clear = (state_q == LCR_H_RSTTX);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            LCR_H_NORMAL: if (fault_hit) state_d = LCR_H_WAIT;
            LCR_H_WAIT:   if (tmr_done) state_d = want_reset ? LCR_H_RSTTX
                                                              : LCR_H_NORMAL;
            LCR_H_RSTTX:  state_d = LCR_H_RSTWT;
            LCR_H_RSTWT:  if (tmr_done) state_d = LCR_H_NORMAL;
            default:      state_d = LCR_H_NORMAL;
        endcase
    end

    // two flops per flag; only the second one feeds the recovery logic
    for (genvar g = 0; g < 2; g++) begin : g_fault_sync
        logic [1:0] sync_q;
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                sync_q <= 2'h0;
            end else begin
                sync_q <= {sync_q[0], fault_raw[g]};
            end
        end
        assign fault_sync[g] = sync_q[1];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= LCR_H_NORMAL;
        end else begin
            state_q <= state_d;
        end
    end

    // values latched at entry, so a port change mid-wait cannot stretch it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tmr_q <= '0;
        end else if (enter_wait) begin
            tmr_q <= host_wait_cycles;
        end else if (enter_rstwt) begin
            tmr_q <= periph_rst_cycles;
        end else if (!tmr_done) begin
            tmr_q <= tmr_q - 1'b1;
        end
    end

    // saturating contention count, cleared once a reset is sent
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= '0;
        end else if (count_clear) begin
            count_q <= '0;
        end else if (count_step) begin
            count_q <= count_inc;
        end
    end

    // link clock from divider, runs free so peripheral timers keep time
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q  <= 4'h0;
            lclk_q <= 1'b0;
        end else if (div_q == 4'(`LCR_HALF_DIV - 1)) begin
            div_q  <= 4'h0;
            lclk_q <= ~lclk_q;
        end else begin
            div_q  <= div_q + 4'h1;
        end
    end

    // outside normal state the host drives LP-11; drives only with tx_req
    wire normal   = in_normal(state_d);
    wire drive_tx = normal & tx_req;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            p_q <= 1'b1;
            n_q <= 1'b1;
        end else begin
            p_q <= drive_tx ? tx_p : 1'b1;
            n_q <= drive_tx ? tx_n : 1'b1;
        end
    end

    // host end never releases, so an idle lane is always transmit-stop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oe_n_q <= 1'b0;
        end else begin
            oe_n_q <= 1'b0;
        end
    end

    // one cycle wide because the transmit state lasts exactly one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rst_entry_q <= 1'b0;
        end else begin
            rst_entry_q <= (state_d == LCR_H_RSTTX);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_q  <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            busy_q  <= ~normal;
            fault_q <= fault_hit;
        end
    end

    assign link.h_p_out   = p_q;
    assign link.h_n_out   = n_q;
    assign link.h_oe_n    = oe_n_q;
    assign link.lane_clk  = lclk_q;
    assign link.rst_entry = rst_entry_q;
    assign busy           = busy_q;
    assign fault_seen     = fault_q;
endmodule : lcr_host

// >>> hdl/lcr_cfg.svh
// Purpose: constants for the lane contention recovery ends
// Assumes: 125 MHz protocol clock
// Notes:   counts are defaults; the host takes live values on ports
`ifndef LCR_CFG_SVH
`define LCR_CFG_SVH
`define LCR_CNT_W          16
`define LCR_THR_W          4
`define LCR_CLK_NS         8
`define LCR_HALF_DIV       8
`define LCR_STOP_SEEN_CYC  16'h0010
`define LCR_PERIPH_RST_CYC 16'h0040
`endif

// >>> hdl/lcr_pkg.sv
// Purpose: shared types for the lane contention recovery ends
// Assumes: lcr_cfg.svh included for widths
// Notes:   none
`include "lcr_cfg.svh"
package lcr_pkg;
    typedef enum logic [1:0] {
        LCR_POL_NEVER  = 2'h0,
        LCR_POL_SINGLE = 2'h1,
        LCR_POL_MULTI  = 2'h2
    } lcr_policy_t;
    typedef logic [`LCR_CNT_W-1:0] lcr_cnt_t;
endpackage : lcr_pkg

// >>> hdl/lcr_link_if.sv
// Purpose: link between host and peripheral lane ends
// Assumes: testbench resolves wired levels from enables
// Notes:   enables are active low; the line pulls up to LP-11 when idle
`timescale 1ns/1ps
interface lcr_link_if;
    logic h_p_out;
    logic h_n_out;
    logic h_oe_n;
    logic p_p_out;
    logic p_n_out;
    logic p_oe_n;
    logic line_p;
    logic line_n;
    logic lane_clk;
    logic rst_entry;
    modport host (output h_p_out, output h_n_out, output h_oe_n, output lane_clk,
                  output rst_entry, input line_p, input line_n);
    modport periph (output p_p_out, output p_n_out, output p_oe_n, input lane_clk,
                    input rst_entry, input line_p, input line_n);
endinterface : lcr_link_if

// >>> hdl/lcr_periph.sv
// Purpose: peripheral lane end of contention recovery
// Assumes: link pins and lane clock are asynchronous to clk
// Notes:   possession timeout counts clk cycles while transmitting
`timescale 1ns/1ps
`include "lcr_cfg.svh"
module lcr_periph (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // i/o cell faults
    input  wire logic                drive_high_contention_fault,
    input  wire logic                drive_low_contention_fault,
    // configuration
    input  wire logic                lane_bidir,
    input  wire lcr_pkg::lcr_cnt_t   possession_cycles,
    // user traffic
    input  wire logic                tx_req,
    input  wire logic                tx_p,
    input  wire logic                tx_n,
    output logic                     low_power_receive_state,
    output logic                     periph_reset,
    output logic                     cmd_enable,
    // link
    lcr_link_if.periph               link
);
    logic [1:0]        hi_s_q;
    logic [1:0]        lo_s_q;
    logic [1:0]        lp_s_q;
    logic [1:0]        ln_s_q;
    logic [1:0]        re_s_q;
    logic [1:0]        lc_s_q;
    logic              lc_prev_q;
    logic              re_prev_q;
    logic              rx_q;
    logic              wait_stop_q;
    lcr_pkg::lcr_cnt_t stop_cnt_q;
    lcr_pkg::lcr_cnt_t own_q;
    lcr_pkg::lcr_cnt_t rst_cnt_q;
    logic              oe_n_q;
    logic              p_q;
    logic              n_q;

    wire fault_hit  = lane_bidir & (hi_s_q[1] | lo_s_q[1]);
    wire stop_line  = lp_s_q[1] & ln_s_q[1];
    wire lclk_rise  = lc_s_q[1] & ~lc_prev_q;
    wire stop_seen  = (stop_cnt_q >= `LCR_STOP_SEEN_CYC);
    wire re_rise    = re_s_q[1] & ~re_prev_q;
    wire own_expire = ~rx_q & tx_req & (own_q >= possession_cycles);
    wire go_rx      = fault_hit | own_expire;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hi_s_q <= 2'h0;
            lo_s_q <= 2'h0;
            lp_s_q <= 2'h3;
            ln_s_q <= 2'h3;
            re_s_q <= 2'h0;
            lc_s_q <= 2'h0;
            lc_prev_q <= 1'b0;
            re_prev_q <= 1'b0;
        end else begin
            hi_s_q <= {hi_s_q[0], drive_high_contention_fault};
            lo_s_q <= {lo_s_q[0], drive_low_contention_fault};
            lp_s_q <= {lp_s_q[0], link.line_p};
            ln_s_q <= {ln_s_q[0], link.line_n};
            re_s_q <= {re_s_q[0], link.rst_entry};
            lc_s_q <= {lc_s_q[0], link.lane_clk};
            lc_prev_q <= lc_s_q[1];
            re_prev_q <= re_s_q[1];
        end
    end

    // stop state must hold for 16 lane clock rising edges before it counts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stop_cnt_q <= '0;
        end else if (!stop_line) begin
            stop_cnt_q <= '0;
        end else if (lclk_rise && !stop_seen) begin
            stop_cnt_q <= stop_cnt_q + 1'b1;
        end
    end

    // receive mode entered on fault or lost possession, ignore bus until stop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_q        <= 1'b1;
            wait_stop_q <= 1'b0;
            own_q       <= '0;
        end else begin
            if (go_rx) begin
                rx_q        <= 1'b1;
                wait_stop_q <= 1'b1;
            end else if (wait_stop_q && stop_seen) begin
                wait_stop_q <= 1'b0;
            end else if (tx_req && !wait_stop_q && rst_cnt_q == '0) begin
                rx_q        <= 1'b0;
            end else if (!tx_req) begin
                rx_q        <= 1'b1;
            end
            own_q <= (rx_q || !tx_req) ? '0 : own_q + 1'b1;
        end
    end

    // reset entry while receiving: hold reset for LCR_PERIPH_RST_CYC cycles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rst_cnt_q <= '0;
        end else if (re_rise && rx_q) begin
            rst_cnt_q <= `LCR_PERIPH_RST_CYC;
        end else if (rst_cnt_q != '0) begin
            rst_cnt_q <= rst_cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oe_n_q <= 1'b1;
            p_q    <= 1'b1;
            n_q    <= 1'b1;
        end else begin
            oe_n_q <= rx_q | go_rx;
            p_q    <= tx_p;
            n_q    <= tx_n;
        end
    end

    logic lprx_q;
    logic prst_q;
    logic cen_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lprx_q <= 1'b1;
            prst_q <= 1'b0;
            cen_q  <= 1'b0;
        end else begin
            lprx_q <= rx_q | go_rx;
            prst_q <= (rst_cnt_q != '0);
            cen_q  <= ~wait_stop_q & ~go_rx & (rst_cnt_q == '0);
        end
    end

    assign link.p_p_out            = p_q;
    assign link.p_n_out            = n_q;
    assign link.p_oe_n             = oe_n_q;
    assign low_power_receive_state = lprx_q;
    assign periph_reset            = prst_q;
    assign cmd_enable              = cen_q;
endmodule : lcr_periph

// >>> verif/lcr_link_checker.sv
// Purpose: link checks between host and peripheral ends
// Assumes: sees link signals plus clk and rst only
// Notes:   peripheral release bounded at 8 cycles
`timescale 1ns/1ps
module lcr_link_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link
    input wire logic h_p_out,
    input wire logic h_n_out,
    input wire logic h_oe_n,
    input wire logic p_oe_n,
    input wire logic lane_clk,
    input wire logic rst_entry
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_strobe;
        rst_entry;
    endsequence
    sequence s_stop;
        h_p_out && h_n_out;
    endsequence
    AST_STROBE_ONE_CYCLE: assert property (s_strobe |=> !rst_entry)
        else $error("reset entry strobe too long");
    AST_HOST_DRIVES: assert property (!h_oe_n)
        else $error("host released the lane");
    AST_STOP_AT_STROBE: assert property (s_strobe |-> s_stop)
        else $error("reset entry sent outside stop");
    AST_STOP_AFTER_STROBE: assert property (s_strobe |=> s_stop [*2])
        else $error("host left stop after reset entry");
    AST_LANE_CLK_HIGH: assert property ($rose(lane_clk) |-> lane_clk [*8] ##1 !lane_clk)
        else $error("lane clock high phase wrong");
    AST_LANE_CLK_LOW: assert property ($fell(lane_clk) |-> !lane_clk [*8] ##1 lane_clk)
        else $error("lane clock low phase wrong");
    AST_PERIPH_RELEASES: assert property (s_strobe |-> ##[1:8] p_oe_n)
        else $error("peripheral kept driving after reset entry");
    AST_PERIPH_STAYS_RX: assert property (s_strobe ##1 p_oe_n |=> p_oe_n [*8])
        else $error("peripheral drove during reset");
endmodule : lcr_link_checker

// >>> verif/lp_contention_recovery_tb.sv
// Purpose: bench for both lane ends of contention recovery
// Assumes: line is wired-and of drivers with pull-up
// Notes:   timeouts shortened to keep the run short
`timescale 1ns/1ps
`include "lcr_cfg.svh"
module lp_contention_recovery_tb;
    logic                   clk, rst, lane_bidir;
    logic                   h_hi, h_lo, p_hi, p_lo;
    logic                   h_req, h_p, h_n, p_req, p_p, p_n;
    logic                   busy, fault_seen, lprx, prst, cmd_en;
    lcr_pkg::lcr_policy_t   policy;
    logic [`LCR_THR_W-1:0]  thr;
    int                     failures = 0, tests_run = 0, n_rst = 0;
    lcr_link_if link ();
    // undriven side floats to the pull-up
    assign link.line_p = (link.h_oe_n | link.h_p_out) & (link.p_oe_n | link.p_p_out);
    assign link.line_n = (link.h_oe_n | link.h_n_out) & (link.p_oe_n | link.p_n_out);
    wire logic [4:0] obs = {link.line_p & link.line_n, cmd_en, prst, lprx, busy};
    lcr_host i_lcr_host (.clk(clk), .rst(rst), .drive_high_contention_fault(h_hi),
        .drive_low_contention_fault(h_lo), .lane_bidir(lane_bidir), .policy(policy),
        .fault_threshold(thr), .host_wait_cycles(16'h0064), .periph_rst_cycles(16'h0050),
        .tx_req(h_req), .tx_p(h_p), .tx_n(h_n), .busy(busy), .fault_seen(fault_seen),
        .link(link.host));
    lcr_periph i_lcr_periph (.clk(clk), .rst(rst), .drive_high_contention_fault(p_hi),
        .drive_low_contention_fault(p_lo), .lane_bidir(lane_bidir),
        .possession_cycles(16'h001E), .tx_req(p_req), .tx_p(p_p), .tx_n(p_n),
        .low_power_receive_state(lprx), .periph_reset(prst), .cmd_enable(cmd_en),
        .link(link.periph));
    lcr_link_checker i_lcr_link_checker (.clk(clk), .rst(rst), .h_p_out(link.h_p_out),
        .h_n_out(link.h_n_out), .h_oe_n(link.h_oe_n), .p_oe_n(link.p_oe_n),
        .lane_clk(link.lane_clk), .rst_entry(link.rst_entry));
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) if (link.rst_entry === 1'h1) n_rst <= n_rst + 1;
    task automatic print_verdict();
        if (failures == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict
    task automatic check(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %b expected %b", $time, got, exp);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    // bounded wait on one observed bit; a timeout ends the run
    task automatic wait_bit(input int i, input logic v, input int lim);
        int k;
        k = 0;
        while (obs[i] !== v && k < lim) begin
            step(1);
            k++;
        end
        if (k >= lim) begin
            failures++;
            $display("ERROR %0t: wait on bit %0d timed out", $time, i);
            print_verdict();
        end
    endtask : wait_bit
    task automatic fault(input logic [3:0] f);
        {h_hi, h_lo, p_hi, p_lo} = f;
        step(4);
        {h_hi, h_lo, p_hi, p_lo} = 4'h0;
    endtask : fault
    initial begin
        rst = 1'h1;
        {h_hi, h_lo, p_hi, p_lo} = 4'h0;
        {h_req, h_p, h_n, p_req, p_p, p_n} = 6'h00;
        lane_bidir = 1'h1;
        policy = lcr_pkg::LCR_POL_SINGLE;
        thr = 4'h2;
        step(6);
        rst = 1'h0;
        step(2);
        check(obs[0], 1'h0);
        check(obs[4], 1'h1);
        check(obs[3], 1'h1);
        lane_bidir = 1'h0;
        fault(4'hA);
        step(6);
        check(busy, 1'h0);
        check(cmd_en, 1'h1);
        lane_bidir = 1'h1;
        // host drives LP-01: request high, p low, n high
        {h_req, h_p, h_n} = 3'h5;
        step(2);
        check(obs[4], 1'h0);
        fault(4'h1);
        step(300);
        check(cmd_en, 1'h0);
        check(link.p_oe_n, 1'h1);
        h_req = 1'h0;
        step(3);
        check(busy, 1'h0);
        check(obs[4], 1'h1);
        wait_bit(3, 1'h1, 400);
        fault(4'h9);
        wait_bit(0, 1'h1, 8);
        check(fault_seen, 1'h1);
        check(obs[4], 1'h1);
        wait_bit(2, 1'h1, 120);
        check(n_rst == 1, 1'h1);
        check(lprx, 1'h1);
        wait_bit(0, 1'h0, 120);
        check(prst, 1'h0);
        check(obs[4], 1'h1);
        wait_bit(3, 1'h1, 400);
        policy = lcr_pkg::LCR_POL_MULTI;
        for (int i = 1; i <= 2; i++) begin
            fault(4'h8);
            wait_bit(0, 1'h1, 8);
            wait_bit(0, 1'h0, 300);
            check(n_rst == i, 1'h1);
            wait_bit(3, 1'h1, 400);
        end
        policy = lcr_pkg::LCR_POL_NEVER;
        fault(4'h4);
        wait_bit(0, 1'h1, 8);
        wait_bit(0, 1'h0, 200);
        check(n_rst == 2, 1'h1);
        policy = lcr_pkg::LCR_POL_SINGLE;
        {p_req, p_p, p_n} = 3'h5;
        step(4);
        check(obs[4], 1'h0);
        check(lprx, 1'h0);
        fault(4'h4);
        wait_bit(1, 1'h1, 40);
        p_req = 1'h0;
        wait_bit(2, 1'h1, 120);
        wait_bit(0, 1'h0, 120);
        check(obs[4], 1'h1);
        wait_bit(3, 1'h1, 400);
        print_verdict();
    end
endmodule : lp_contention_recovery_tb
